// ---- gated_sixteen_bit_timer.sv ----
// gated sixteen-bit timer with apb register slave and overflow interrupt
`timescale 1ns/1ps
module gated_sixteen_bit_timer
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [gated_timer_pkg::ADDR_WIDTH-1:0] paddr,
    input wire logic [gated_timer_pkg::DATA_WIDTH-1:0] pwdata,
    output logic [gated_timer_pkg::DATA_WIDTH-1:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic ext_count_pin,
    input wire logic crystal_in_pin,
    output logic crystal_out_pin,
    input wire logic gate_input,
    input wire logic sleep,
    output logic irq,
    output logic wakeup
);
    logic [gated_timer_pkg::COUNT_WIDTH-1:0] count;
    logic [1:0] clock_source_sel;
    logic [1:0] prescale_sel;
    logic crystal_osc_enable;
    logic sync_disable;
    logic counter_on;
    logic gate_enable;
    logic gate_polarity;
    logic overflow_flag;
    logic overflowMask;
    logic [gated_timer_pkg::PRESCALE_WIDTH-1:0] prescaleCount;
    logic [1:0] phase;
    logic extMeta;
    logic extSync;
    logic crystalMeta;
    logic crystalSync;
    logic gateMeta;
    logic gateSync;
    logic srcPrev;
    logic armed;
    logic extPending;

    logic accessDone;
    logic writeStrobe;
    logic writeLow;
    logic writeHigh;
    logic countWrite;
    logic externalSel;
    logic srcLevel;
    logic extRise;
    logic extFall;
    logic gateOpen;
    logic runEnable;
    logic sleepRun;
    logic srcTick;
    logic [gated_timer_pkg::PRESCALE_WIDTH-1:0] divideLast;
    logic scaledTick;
    logic overflowEvent;
    logic next_overflow_flag;

    function automatic logic hits(input logic [gated_timer_pkg::ADDR_WIDTH-1:0] addr,
                                  input logic [gated_timer_pkg::ADDR_WIDTH-1:0] offset);
        hits = (addr == offset);
    endfunction

    function automatic logic mapped(input logic [gated_timer_pkg::ADDR_WIDTH-1:0] addr);
        mapped = hits(addr, gated_timer_pkg::OFF_COUNT_LOW)
            || hits(addr, gated_timer_pkg::OFF_COUNT_HIGH)
            || hits(addr, gated_timer_pkg::OFF_CONTROL)
            || hits(addr, gated_timer_pkg::OFF_GATE)
            || hits(addr, gated_timer_pkg::OFF_INT_STATUS)
            || hits(addr, gated_timer_pkg::OFF_INT_MASK);
    endfunction

    assign accessDone = psel && penable && pready;
    assign writeStrobe = accessDone && pwrite && !pslverr;
    assign writeLow = writeStrobe && hits(paddr, gated_timer_pkg::OFF_COUNT_LOW);
    assign writeHigh = writeStrobe && hits(paddr, gated_timer_pkg::OFF_COUNT_HIGH);
    assign countWrite = writeLow || writeHigh;

    // two flops on every pin before use
    // gate level is read straight from these, with no further filtering
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            extMeta <= 1'b0;
            extSync <= 1'b0;
            crystalMeta <= 1'b0;
            crystalSync <= 1'b0;
            gateMeta <= 1'b0;
            gateSync <= 1'b0;
        end
        else
        begin
            extMeta <= ext_count_pin;
            extSync <= extMeta;
            crystalMeta <= crystal_in_pin;
            crystalSync <= crystalMeta;
            gateMeta <= gate_input;
            gateSync <= gateMeta;
        end
    end

    // crystal driver runs while enabled, sleep or not
    // plain inverted echo of the input; no analogue oscillator behind it
    always_ff @(posedge clk)
    begin
        if (rst)
            crystal_out_pin <= 1'b0;
        else
            crystal_out_pin <= crystal_osc_enable && !crystalSync;
    end

    // instruction clock phases, one instruction per four system clocks
    // runs free from reset, so instruction ticks keep one fixed alignment
    always_ff @(posedge clk)
    begin
        if (rst)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    end

    assign externalSel = (clock_source_sel == gated_timer_pkg::SRC_EXTERNAL);
    // pin or crystal chosen by oscillator enable
    assign srcLevel = crystal_osc_enable ? crystalSync : extSync;
    // rising edge of the external source
    assign extRise = externalSel && srcLevel && !srcPrev && armed;
    assign extFall = srcPrev && !srcLevel;
    assign gateOpen = (gateSync == gate_polarity);
    // only asynchronous external counting survives sleep
    assign sleepRun = !sleep || (externalSel && sync_disable);
    assign runEnable = counter_on && (!gate_enable || gateOpen) && sleepRun;

    always_ff @(posedge clk)
    begin
        if (rst)
            srcPrev <= 1'b0;
        else
            srcPrev <= srcLevel;
    end

    // falling edge arms the counter after enable, write or disable
    always_ff @(posedge clk)
    begin
        if (rst || !counter_on || countWrite)
            armed <= 1'b0;
        else if (externalSel && extFall)
            armed <= 1'b1;
    end

    // synchronised edges wait for the last instruction phase
    // dropping a pending edge on mode switch loses at most one count
    always_ff @(posedge clk)
    begin
        if (rst || !counter_on || countWrite || sync_disable || !externalSel)
            extPending <= 1'b0;
        // an edge on the last phase counts at once and must not pend too
        else if (phase == gated_timer_pkg::PHASE_LAST)
            extPending <= 1'b0;
        else if (extRise)
            extPending <= 1'b1;
    end

    always_comb
    begin
        srcTick = 1'b0;
        unique case (clock_source_sel)
            gated_timer_pkg::SRC_INSTRUCTION:
                srcTick = (phase == gated_timer_pkg::PHASE_LAST);
            gated_timer_pkg::SRC_SYSTEM:
                srcTick = 1'b1;
            gated_timer_pkg::SRC_EXTERNAL:
                srcTick = sync_disable ? extRise
                    : ((extPending || extRise) && phase == gated_timer_pkg::PHASE_LAST);
            gated_timer_pkg::SRC_RESERVED:
                srcTick = 1'b0;
        endcase
    end

    // divide by one, two, four or eight
    assign divideLast = gated_timer_pkg::PRESCALE_WIDTH'((1 << prescale_sel) - 1);
    assign scaledTick = srcTick && runEnable && (prescaleCount == divideLast);

    // hidden prescaler cleared by count writes
    // restarting the divide keeps the first tick after a write a full period away
    always_ff @(posedge clk)
    begin
        if (rst || countWrite)
            prescaleCount <= '0;
        else if (srcTick && runEnable)
            prescaleCount <= (prescaleCount == divideLast) ? '0
                : prescaleCount + gated_timer_pkg::PRESCALE_WIDTH'(1);
    end

    // byte writes replace the live value and win over an increment
    // writing while running drops the same-cycle increment and restarts the prescaler; stop the counter first
    always_ff @(posedge clk)
    begin
        if (rst)
            count <= gated_timer_pkg::COUNT_RESET;
        else if (countWrite)
        begin
            if (writeLow)
                count[7:0] <= pwdata[7:0];
            if (writeHigh)
                count[15:8] <= pwdata[7:0];
        end
        else if (scaledTick)
            count <= count + gated_timer_pkg::COUNT_WIDTH'(1);
    end

    // wrap sets the flag; a new wrap beats a same-cycle clear
    assign overflowEvent = scaledTick && !countWrite
        && (count == gated_timer_pkg::COUNT_ALL_ONES);

    always_comb
    begin
        next_overflow_flag = overflow_flag;
        if (writeStrobe && hits(paddr, gated_timer_pkg::OFF_INT_STATUS)
            && pwdata[gated_timer_pkg::INT_OVERFLOW_BIT])
            next_overflow_flag = 1'b0;
        if (overflowEvent)
            next_overflow_flag = 1'b1;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            overflow_flag <= 1'b0;
        else
            overflow_flag <= next_overflow_flag;
    end

    // unmasked overflow raises the interrupt and wakes from sleep
    // follows the stored flag one cycle behind, so a clear drops irq one edge after the write
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            irq <= 1'b0;
            wakeup <= 1'b0;
        end
        else
        begin
            irq <= overflow_flag && overflowMask;
            wakeup <= sleep && overflow_flag && overflowMask;
        end
    end

    // control, gate and interrupt mask registers
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            clock_source_sel <= gated_timer_pkg::CONTROL_RESET[7:6];
            prescale_sel <= gated_timer_pkg::CONTROL_RESET[5:4];
            crystal_osc_enable <= 1'b0;
            sync_disable <= 1'b0;
            counter_on <= 1'b0;
            gate_enable <= 1'b0;
            gate_polarity <= 1'b0;
            overflowMask <= 1'b0;
        end
        else if (writeStrobe)
        begin
            if (hits(paddr, gated_timer_pkg::OFF_CONTROL))
            begin
                clock_source_sel <= pwdata[gated_timer_pkg::CTRL_SOURCE_LSB +: 2];
                prescale_sel <= pwdata[gated_timer_pkg::CTRL_PRESCALE_LSB +: 2];
                crystal_osc_enable <= pwdata[gated_timer_pkg::CTRL_OSC_ENABLE_BIT];
                sync_disable <= pwdata[gated_timer_pkg::CTRL_SYNC_DISABLE_BIT];
                counter_on <= pwdata[gated_timer_pkg::CTRL_ON_BIT];
            end
            if (hits(paddr, gated_timer_pkg::OFF_GATE))
            begin
                gate_enable <= pwdata[gated_timer_pkg::GATE_ENABLE_BIT];
                gate_polarity <= pwdata[gated_timer_pkg::GATE_POLARITY_BIT];
            end
            if (hits(paddr, gated_timer_pkg::OFF_INT_MASK))
                overflowMask <= pwdata[gated_timer_pkg::INT_OVERFLOW_BIT];
        end
    end

    // one wait state: pready rises in the second access cycle
    // unmapped offsets answer with pslverr and change no register
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && penable && !pready;
            pslverr <= psel && penable && !pready && !mapped(paddr);
        end
    end

    // reads sample the live count with no side effect
    always_ff @(posedge clk)
    begin
        if (rst)
            prdata <= '0;
        else if (psel && penable && !pready && !pwrite)
        begin
            prdata <= '0;
            if (hits(paddr, gated_timer_pkg::OFF_COUNT_LOW))
                prdata[7:0] <= count[7:0];
            if (hits(paddr, gated_timer_pkg::OFF_COUNT_HIGH))
                prdata[7:0] <= count[15:8];
            if (hits(paddr, gated_timer_pkg::OFF_CONTROL))
            begin
                prdata[gated_timer_pkg::CTRL_SOURCE_LSB +: 2] <= clock_source_sel;
                prdata[gated_timer_pkg::CTRL_PRESCALE_LSB +: 2] <= prescale_sel;
                prdata[gated_timer_pkg::CTRL_OSC_ENABLE_BIT] <= crystal_osc_enable;
                prdata[gated_timer_pkg::CTRL_SYNC_DISABLE_BIT] <= sync_disable;
                prdata[gated_timer_pkg::CTRL_ON_BIT] <= counter_on;
            end
            if (hits(paddr, gated_timer_pkg::OFF_GATE))
            begin
                prdata[gated_timer_pkg::GATE_ENABLE_BIT] <= gate_enable;
                prdata[gated_timer_pkg::GATE_POLARITY_BIT] <= gate_polarity;
                prdata[gated_timer_pkg::GATE_LEVEL_BIT] <= gateSync;
            end
            if (hits(paddr, gated_timer_pkg::OFF_INT_STATUS))
                prdata[gated_timer_pkg::INT_OVERFLOW_BIT] <= overflow_flag;
            if (hits(paddr, gated_timer_pkg::OFF_INT_MASK))
                prdata[gated_timer_pkg::INT_OVERFLOW_BIT] <= overflowMask;
        end
    end
endmodule

// ---- gated_timer_pkg.sv ----
// constants and register map of the gated sixteen-bit timer
package gated_timer_pkg;
    localparam int COUNT_WIDTH = 16;
    localparam int ADDR_WIDTH = 8;
    localparam int DATA_WIDTH = 32;
    localparam int PRESCALE_WIDTH = 3;

    localparam logic [7:0] OFF_COUNT_LOW = 8'h00;
    localparam logic [7:0] OFF_COUNT_HIGH = 8'h04;
    localparam logic [7:0] OFF_CONTROL = 8'h08;
    localparam logic [7:0] OFF_GATE = 8'h0c;
    localparam logic [7:0] OFF_INT_STATUS = 8'h10;
    localparam logic [7:0] OFF_INT_MASK = 8'h14;

    localparam int CTRL_ON_BIT = 0;
    localparam int CTRL_SYNC_DISABLE_BIT = 2;
    localparam int CTRL_OSC_ENABLE_BIT = 3;
    localparam int CTRL_PRESCALE_LSB = 4;
    localparam int CTRL_SOURCE_LSB = 6;
    localparam int GATE_LEVEL_BIT = 2;
    localparam int GATE_POLARITY_BIT = 6;
    localparam int GATE_ENABLE_BIT = 7;
    localparam int INT_OVERFLOW_BIT = 0;

    localparam logic [1:0] SRC_INSTRUCTION = 2'h0;
    localparam logic [1:0] SRC_SYSTEM = 2'h1;
    localparam logic [1:0] SRC_EXTERNAL = 2'h2;
    localparam logic [1:0] SRC_RESERVED = 2'h3;

    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [COUNT_WIDTH-1:0] COUNT_RESET = 16'h0000;
    localparam logic [COUNT_WIDTH-1:0] COUNT_ALL_ONES = 16'hffff;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] GATE_RESET = 8'h00;
endpackage

// ---- gated_timer_monitor.sv ----
// bus timing, interrupt and crystal output checker for the gated timer
`timescale 1ns/1ps
module gated_timer_monitor
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic crystal_in_pin,
    input wire logic crystal_out_pin,
    input wire logic sleep,
    input wire logic irq,
    input wire logic wakeup
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    a_one_wait:
    assert property ($rose(psel && penable) |=> pready) else $error("pready late");
    a_ready_pulse:
    assert property (pready |=> !pready) else $error("pready held");
    a_err_ready:
    assert property (pslverr |-> pready && psel && penable) else $error("stray pslverr");
    a_read_bytes:
    assert property (pready && !pwrite |-> prdata[31:8] == 24'h0) else $error("upper bits set");
    a_err_zero:
    assert property (pslverr && !pwrite |-> prdata == 32'h0) else $error("refused read data");
    a_wake_sleep:
    assert property (wakeup |-> $past(sleep) && irq) else $error("wakeup outside sleep");
    a_irq_clear:
    assert property ($fell(irq) |-> $past(pready && pwrite, 2)) else $error("irq dropped alone");
    // five samples cover the two sync flops plus the output register
    a_xtal_invert:
    assert property (crystal_in_pin [*5] |-> !crystal_out_pin) else $error("crystal out level");
endmodule

// ---- timer_pin_source.sv ----
// pin-side model: count pin, crystal input and gate level
`timescale 1ns/1ps
module timer_pin_source
(
    input wire logic clk,
    output logic countPin,
    output logic crystalPin,
    output logic gatePin
);
    initial
    begin
        countPin = 1'b0;
        crystalPin = 1'b0;
        gatePin = 1'b0;
    end
    task automatic pulses(input logic xtal, input int n, input int half);
        for (int i = 0; i < 2 * n; i++)
        begin
            @(posedge clk);
            if (xtal)
                crystalPin <= ~crystalPin;
            else
                countPin <= ~countPin;
            repeat (half - 1) @(posedge clk);
        end
    endtask
    task automatic setGate(input logic lvl);
        @(posedge clk);
        gatePin <= lvl;
    endtask
    task automatic window(input logic lvl, input int g);
        setGate(lvl);
        repeat (g - 1) @(posedge clk);
        setGate(~lvl);
    endtask
endmodule

// ---- gated_sixteen_bit_timer_tb.sv ----
// self-checking bench for the gated sixteen-bit timer
`timescale 1ns/1ps
module gated_sixteen_bit_timer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic sleep = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, countPin, crystalPin, crystalOut, gatePin, irq, wakeup;
    logic [32:0] expq[$];
    logic [1:0] srcTab[4] = '{2'h1, 2'h0, 2'h3, 2'h1};
    int mismatches = 0;
    int samplesChecked = 0;
    int k;
    int g;
    logic [15:0] e;
    always #20 clk = ~clk;
    gated_sixteen_bit_timer u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ext_count_pin(countPin), .crystal_in_pin(crystalPin),
        .crystal_out_pin(crystalOut), .gate_input(gatePin), .sleep(sleep), .irq(irq),
        .wakeup(wakeup));
    timer_pin_source u_src (.clk(clk), .countPin(countPin), .crystalPin(crystalPin),
        .gatePin(gatePin));
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        samplesChecked++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // request held until pready is sampled high at a rising edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d});
    endtask
    task automatic rd(input logic [7:0] a, input logic [32:0] x);
        expq.push_back(x);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic setCount(input logic [15:0] v);
        wr(gated_timer_pkg::OFF_COUNT_LOW, v[7:0]);
        wr(gated_timer_pkg::OFF_COUNT_HIGH, v[15:8]);
    endtask
    task automatic getCount(input logic [15:0] v);
        rd(gated_timer_pkg::OFF_COUNT_LOW, {25'h0, v[7:0]});
        rd(gated_timer_pkg::OFF_COUNT_HIGH, {25'h0, v[15:8]});
    endtask
    task automatic tally_and_finish;
        $display("comparisons %0d mismatches %0d", samplesChecked, mismatches);
        if (mismatches == 0 && samplesChecked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk)
        if (psel && penable && pready && !pwrite)
            check({pslverr, prdata}, expq.pop_front());
    initial
    begin
        void'($urandom(32'h9980));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 28; a += 4)
            rd(a[7:0], {a == 24, 32'h0});
        $display("test reset done");
        e = 16'($urandom);
        setCount(e);
        getCount(e);
        $display("test byte write done");
        for (int i = 0; i < 8; i++)
        begin
            g = 4 * $urandom_range(2, 9);
            k = i / 2;
            u_src.setGate(~i[0]);
            wr(gated_timer_pkg::OFF_GATE, {1'b1, i[0], 6'h0});
            setCount(16'h0);
            wr(gated_timer_pkg::OFF_CONTROL, {srcTab[k], 5'h0, k != 3});
            u_src.window(i[0], g);
            repeat (6) @(posedge clk);
            wr(gated_timer_pkg::OFF_CONTROL, 8'h0);
            getCount(16'(k == 0 ? g : k == 1 ? g / 4 : 0));
        end
        $display("test gated sources done");
        wr(gated_timer_pkg::OFF_GATE, 8'h0);
        // mode fixed per run, never switched while counting
        for (int i = 0; i < 8; i++)
        begin
            k = $urandom_range(1, 3);
            wr(gated_timer_pkg::OFF_CONTROL, 8'h0);
            setCount(16'h0);
            wr(gated_timer_pkg::OFF_CONTROL, {2'h2, i[2:1], 1'b0, i[0], 2'h1});
            u_src.pulses(1'b0, 8 * k + 1, $urandom_range(3, 6));
            repeat (8) @(posedge clk);
            getCount(16'((8 * k) >> i[2:1]));
        end
        $display("test external pin done");
        wr(gated_timer_pkg::OFF_INT_MASK, 8'h1);
        wr(gated_timer_pkg::OFF_INT_STATUS, 8'h1);
        setCount(16'hfc00);
        wr(gated_timer_pkg::OFF_CONTROL, 8'h8d);
        sleep <= 1'b1;
        u_src.pulses(1'b1, 1025, 5);
        repeat (8) @(posedge clk);
        check({32'h0, wakeup}, 33'h1);
        check({32'h0, irq}, 33'h1);
        sleep <= 1'b0;
        rd(gated_timer_pkg::OFF_INT_STATUS, 33'h1);
        wr(gated_timer_pkg::OFF_INT_MASK, 8'h0);
        @(posedge clk);
        check({32'h0, irq}, 33'h0);
        wr(gated_timer_pkg::OFF_INT_MASK, 8'h1);
        @(posedge clk);
        check({32'h0, irq}, 33'h1);
        wr(gated_timer_pkg::OFF_INT_STATUS, 8'h1);
        @(posedge clk);
        check({32'h0, irq}, 33'h0);
        rd(gated_timer_pkg::OFF_INT_STATUS, 33'h0);
        $display("test crystal overflow done");
        tally_and_finish();
    end
    initial
    begin
        repeat (60000) @(posedge clk);
        mismatches++;
        tally_and_finish();
    end
endmodule
bind gated_sixteen_bit_timer gated_timer_monitor u_mon (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .crystal_in_pin(crystal_in_pin), .crystal_out_pin(crystal_out_pin), .sleep(sleep),
    .irq(irq), .wakeup(wakeup));
